// >>> hdl/isc_regs.svh
`ifndef ISC_REGS_SVH
`define ISC_REGS_SVH

// register indices on the 3-bit register port
`define ISC_A_CTRL 3'h0
`define ISC_A_SADDR 3'h1
`define ISC_A_MASK 3'h2
`define ISC_A_RXBUF 3'h3
`define ISC_A_TXHOLD 3'h4
`define ISC_A_BRG 3'h5
`define ISC_A_STAT 3'h6
`define ISC_A_MTX 3'h7

// port_control fields
`define ISC_B_EN 15
`define ISC_B_SIDL 13
`define ISC_B_REL 12
`define ISC_B_IPMI 11
`define ISC_B_TEN_BIT_ADDRESS_SELECT 10
`define ISC_B_SLW 9
`define ISC_B_SMB 8
`define ISC_B_GENERAL_CALL_ENABLE 7
`define ISC_B_STRETCH_ENABLE 6
`define ISC_CTRL_RST 16'h1000
`define ISC_CTRL_WMASK 16'hafff

// status fields
`define ISC_S_TBF 0
`define ISC_S_RBF 1
`define ISC_S_RW 2
`define ISC_S_GC 3
`define ISC_S_A10 4
`define ISC_S_BCL 5
`define ISC_S_ROV 6

`define ISC_BRG_RST 16'h0002
`define ISC_LAST_BIT 4'h8
`define ISC_ACK_BIT 4'h9

`endif

// >>> hdl/isc_pkg.sv
package isc_pkg;
   typedef enum logic [2:0] {SL_IDLE, SL_ADDR, SL_ADDR2, SL_RX, SL_TX}
      isc_slv_t;
   typedef enum logic [1:0] {MS_IDLE, MS_LOW, MS_RISE, MS_HIGH} isc_mst_t;
   typedef enum logic [2:0] {AC_GCALL, AC_RSVD, AC_HSCODE, AC_VALID, AC_TEN}
      isc_acls_t;
endpackage

// >>> hdl/isc_sync.sv
`timescale 1ns/1ns
module isc_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys, // system clock
   input wire logic rst, // synchronous reset
   input wire logic [W-1:0] d, // asynchronous inputs
   output logic [W-1:0] q // synchronised copies
);
   logic [W-1:0] meta;

   // open-drain lines idle high, so reset to ones
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         meta <= '1;
         q <= '1;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule // isc_sync

// >>> hdl/isc_brg.sv
`timescale 1ns/1ns
module isc_brg #(
   parameter int W = 16
) (
   input wire logic clk_sys, // system clock
   input wire logic rst, // synchronous reset
   input wire logic load, // reload from reload value
   input wire logic hold, // suspend counting
   input wire logic [W-1:0] reload, // reload value
   output logic zero // counter at zero
);
   logic [W-1:0] cnt;

   // counts down and parks at zero until the next load
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt <= '0;
      end else if (load) begin
         cnt <= reload;
      end else if (!hold && cnt != '0) begin
         cnt <= cnt - 1'b1;
      end
   end

   assign zero = (cnt == '0);
endmodule // isc_brg

// >>> hdl/isc_top.sv
// Contract
// - ten-bit select clear: match received address with low seven bits
// - ten-bit mode: header 11110+A9A8, then next byte against low eight bits
// - classify 7-bit addresses: call, reserved, hs, valid, ten-bit, reserved
// - set mask bits make address positions don't-care, both address modes
// - masking only acts while accept-all is clear
// - accept-all set: every address is accepted and acted upon
// - zero address with write: general call only when enabled, event raised; the code answers it only while ten-bit select is clear
// - transmit: after ninth fall, empty buffer clears release, holds clock
// - transmit stretching happens regardless of stretch enable
// - clock held low until software sets release
// - stretch enable: hold clock after every received data byte
// - stretch enable clear: software clears of release are ignored
// - a control bit disables slew limiting, needed for 1 MHz
// - master releases clock: counter suspended until high, then reloaded
// - clock high time at least one full counter rollover
// - master drives 1, samples 0 while clock high: collision, event, idle
// - configuration bit picks primary (1) or alternate (0) pin pair
// - counter counts down to zero and stops until reloaded
// - completed byte moves to receive buffer with a pulse
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "isc_regs.svh"
module isc_top #(
   parameter int BRG_W = 16
) (
   input wire logic clk_sys, // system clock, 100 MHz
   input wire logic rst, // synchronous reset, active high
   input wire logic [2:0] addr, // register index
   input wire logic [15:0] wr_data, // write data
   input wire logic wr_en, // write strobe
   input wire logic rd_en, // read strobe
   output logic [15:0] rd_data, // read data, cycle after rd_en
   input wire logic [3:0] pin_in, // {alt sda, alt scl, sda, scl}
   output logic [3:0] pin_out, // pin drive level, always low
   output logic [3:0] pin_oe, // high while pulling the pin low
   input wire logic alternate_pin_select, // strap, 1 = primary pins
   output logic slew_control_disable, // to pad slew control
   output logic smbus_level_enable, // to pad input thresholds
   output logic master_event_flag, // master event pulse
   output logic slave_event, // slave address event pulse
   output logic rx_done // received byte pulse
);
   generate
      if (BRG_W < 2 || BRG_W > 16) begin : g_bad_width
         $error("BRG_W must be 2 to 16");
      end
   endgenerate

   function automatic logic masked_eq(input logic [7:0] a, b, m);
      masked_eq = ((a ^ b) & ~m) == 8'h00;
   endfunction

   function automatic isc_pkg::isc_acls_t addr_class(input logic [6:0] a);
      if (a == 7'h00) addr_class = isc_pkg::AC_GCALL;
      else if (a <= 7'h03) addr_class = isc_pkg::AC_RSVD;
      else if (a <= 7'h07) addr_class = isc_pkg::AC_HSCODE;
      else if (a <= 7'h77) addr_class = isc_pkg::AC_VALID;
      else if (a <= 7'h7b) addr_class = isc_pkg::AC_TEN;
      else addr_class = isc_pkg::AC_RSVD;
   endfunction

   logic [4:0] sync_q;
   logic pin_sel, sel_taken;
   logic [1:0] sel_wait;
   logic scl_s, sda_s, scl_q, sda_q;
   logic [15:0] ctrl;
   logic [9:0] saddr, amask;
   logic [7:0] rxbuf, thr, mtx, shreg, txsh;
   logic [BRG_W-1:0] brg_rl;
   logic transmit_buffer_full, rbf, slv_rw, gc_stat, add10, bcl, rov;
   isc_pkg::isc_slv_t ss;
   isc_pkg::isc_mst_t m_st;
   logic [3:0] bit_cnt, mbit;
   logic ack_drv, tx_low, ten_hit, txload, rx_data;
   logic slv_scl_low, m_scl_low, m_sda_low, m_ev;
   logic brg_load, brg_zero;

   isc_sync #(.W(5)) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .d({alternate_pin_select, pin_in}),
      .q(sync_q)
   );

   // the strap is caught once, on the third clock after reset, when its
   // value has passed both stages of the synchroniser
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pin_sel <= 1'b1;
         sel_taken <= 1'b0;
         sel_wait <= 2'h0;
      end else if (!sel_taken) begin
         if (sel_wait == 2'h2) begin
            pin_sel <= sync_q[4];
            sel_taken <= 1'b1;
         end else begin
            sel_wait <= sel_wait + 2'h1;
         end
      end
   end

   assign scl_s = pin_sel ? sync_q[0] : sync_q[2];
   assign sda_s = pin_sel ? sync_q[1] : sync_q[3];

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   wire en = ctrl[`ISC_B_EN];
   wire stretch_enable = ctrl[`ISC_B_STRETCH_ENABLE];
   wire ten_bit_address_select = ctrl[`ISC_B_TEN_BIT_ADDRESS_SELECT];
   wire accept_all_addresses_enable = ctrl[`ISC_B_IPMI];
   wire scl_rise = scl_s && !scl_q;
   wire scl_fall = !scl_s && scl_q;
   wire start_c = scl_s && scl_q && sda_q && !sda_s;
   wire stop_c = scl_s && scl_q && !sda_q && sda_s;
   wire ack_slot = scl_fall && bit_cnt == `ISC_LAST_BIT &&
                   ss != isc_pkg::SL_IDLE;
   wire ack_end = scl_fall && bit_cnt == `ISC_ACK_BIT;

   wire wr_ctrl = wr_en && addr == `ISC_A_CTRL;
   wire wr_thr = wr_en && addr == `ISC_A_TXHOLD;
   wire wr_stat = wr_en && addr == `ISC_A_STAT;
   wire rd_rx = rd_en && addr == `ISC_A_RXBUF;
   wire m_go = wr_en && addr == `ISC_A_MTX && en && m_st == isc_pkg::MS_IDLE;

   // address recognition
   wire [9:0] msk_eff = accept_all_addresses_enable ? 10'h000 : amask;
   wire isc_pkg::isc_acls_t acls = addr_class(shreg[7:1]);
   wire gc_hit = ctrl[`ISC_B_GENERAL_CALL_ENABLE] && acls == isc_pkg::AC_GCALL &&
                 !shreg[0];
   wire own7 = acls == isc_pkg::AC_VALID &&
      masked_eq({1'b0, shreg[7:1]}, {1'b0, saddr[6:0]},
                {1'b0, msk_eff[6:0]});
   wire hdr_hit = acls == isc_pkg::AC_TEN &&
      masked_eq({6'h00, shreg[2:1]}, {6'h00, saddr[9:8]},
                {6'h00, msk_eff[9:8]});
   wire lo_hit = accept_all_addresses_enable || masked_eq(shreg, saddr[7:0], msk_eff[7:0]);
   wire addr_ok = ten_bit_address_select ? accept_all_addresses_enable || (hdr_hit && (!shreg[0] || ten_hit))
                       : accept_all_addresses_enable || own7 || gc_hit;
   wire ev_match = ack_slot && ((ss == isc_pkg::SL_ADDR && addr_ok) ||
                                (ss == isc_pkg::SL_ADDR2 && lo_hit));
   wire ev_rx = ack_slot && ss == isc_pkg::SL_RX;
   wire hw_rel_clr = ack_end &&
      ((ss == isc_pkg::SL_TX && !transmit_buffer_full) ||
       (ss == isc_pkg::SL_RX && stretch_enable && rx_data));

   // slave protocol engine
   always_ff @(posedge clk_sys) begin
      if (rst || !en) begin
         ss <= isc_pkg::SL_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         txsh <= 8'h00;
         ack_drv <= 1'b0;
         tx_low <= 1'b0;
         ten_hit <= 1'b0;
         txload <= 1'b0;
         rx_data <= 1'b0;
      end else if (start_c) begin
         ss <= isc_pkg::SL_ADDR;
         bit_cnt <= 4'h0;
         ack_drv <= 1'b0;
         tx_low <= 1'b0;
         txload <= 1'b0;
      end else if (stop_c) begin
         ss <= isc_pkg::SL_IDLE;
         ten_hit <= 1'b0;
         ack_drv <= 1'b0;
         tx_low <= 1'b0;
      end else begin
         if (scl_rise && ss != isc_pkg::SL_IDLE &&
             bit_cnt != `ISC_ACK_BIT) begin
            if (bit_cnt != `ISC_LAST_BIT)
               shreg <= {shreg[6:0], sda_s};
            // a master nack ends the read
            if (ss == isc_pkg::SL_TX && bit_cnt == `ISC_LAST_BIT && sda_s)
               ss <= isc_pkg::SL_IDLE;
            bit_cnt <= bit_cnt + 4'h1;
         end
         if (scl_fall && ss == isc_pkg::SL_TX && bit_cnt < `ISC_LAST_BIT)
            tx_low <= txload && !txsh[~bit_cnt[2:0]];
         if (ack_slot) begin
            rx_data <= (ss == isc_pkg::SL_RX);
            tx_low <= 1'b0;
            case (ss)
               isc_pkg::SL_ADDR: begin
                  if (addr_ok) begin
                     ack_drv <= 1'b1;
                     if (shreg[0])
                        ss <= isc_pkg::SL_TX;
                     else if (ten_bit_address_select)
                        ss <= isc_pkg::SL_ADDR2;
                     else
                        ss <= isc_pkg::SL_RX;
                  end else begin
                     ss <= isc_pkg::SL_IDLE;
                  end
               end
               isc_pkg::SL_ADDR2: begin
                  if (lo_hit) begin
                     ack_drv <= 1'b1;
                     ten_hit <= 1'b1;
                     ss <= isc_pkg::SL_RX;
                  end else begin
                     ss <= isc_pkg::SL_IDLE;
                  end
               end
               isc_pkg::SL_RX: ack_drv <= 1'b1;
               default: ack_drv <= 1'b0;
            endcase
         end
         if (ack_end) begin
            ack_drv <= 1'b0;
            bit_cnt <= 4'h0;
            txload <= 1'b0;
         end
         // load while the clock is still low, first bit goes out at once
         if (ss == isc_pkg::SL_TX && !txload && transmit_buffer_full && bit_cnt == 4'h0) begin
            txsh <= thr;
            txload <= 1'b1;
            tx_low <= !thr[7];
         end
      end
   end

   // hardware clearing of release beats a software set in the same cycle,
   // so a stretch point is never missed
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctrl <= `ISC_CTRL_RST;
      end else begin
         if (wr_ctrl) begin
            ctrl <= wr_data & `ISC_CTRL_WMASK;
            if (wr_data[`ISC_B_REL] || !stretch_enable)
               ctrl[`ISC_B_REL] <= wr_data[`ISC_B_REL] || ctrl[`ISC_B_REL];
            else
               ctrl[`ISC_B_REL] <= 1'b0;
         end
         if (hw_rel_clr)
            ctrl[`ISC_B_REL] <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         saddr <= 10'h000;
         amask <= 10'h000;
         thr <= 8'h00;
         brg_rl <= BRG_W'(`ISC_BRG_RST);
      end else if (wr_en) begin
         if (addr == `ISC_A_SADDR)
            saddr <= wr_data[9:0];
         else if (addr == `ISC_A_MASK)
            amask <= wr_data[9:0];
         else if (addr == `ISC_A_TXHOLD)
            thr <= wr_data[7:0];
         else if (addr == `ISC_A_BRG)
            brg_rl <= wr_data[BRG_W-1:0];
      end
   end

   // status flags: a hardware set wins over any clear in the same cycle
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         transmit_buffer_full <= 1'b0;
         rbf <= 1'b0;
         rov <= 1'b0;
         bcl <= 1'b0;
         slv_rw <= 1'b0;
         gc_stat <= 1'b0;
         add10 <= 1'b0;
         rxbuf <= 8'h00;
      end else begin
         if (wr_thr)
            transmit_buffer_full <= 1'b1;
         else if (ack_slot && ss == isc_pkg::SL_TX)
            transmit_buffer_full <= 1'b0;
         if (ev_rx) begin
            rxbuf <= shreg;
            rbf <= 1'b1;
         end else if (rd_rx) begin
            rbf <= 1'b0;
         end
         if (ev_rx && rbf)
            rov <= 1'b1;
         else if (wr_stat && wr_data[`ISC_S_ROV])
            rov <= 1'b0;
         if (m_st == isc_pkg::MS_HIGH && !m_sda_low && !sda_s)
            bcl <= 1'b1;
         else if (wr_stat && wr_data[`ISC_S_BCL])
            bcl <= 1'b0;
         if (ev_match && ss == isc_pkg::SL_ADDR)
            slv_rw <= shreg[0];
         if (ev_match && ss == isc_pkg::SL_ADDR && !ten_bit_address_select && gc_hit)
            gc_stat <= 1'b1;
         else if (stop_c)
            gc_stat <= 1'b0;
         if (ev_match && ss == isc_pkg::SL_ADDR2)
            add10 <= 1'b1;
         else if (stop_c)
            add10 <= 1'b0;
      end
   end

   // master byte shifter, timed by the bit-rate counter
   wire m_coll = m_st == isc_pkg::MS_HIGH && !m_sda_low && !sda_s;
   assign brg_load = m_go ||
      (m_st == isc_pkg::MS_RISE && scl_s) ||
      (m_st == isc_pkg::MS_HIGH && brg_zero && !m_coll &&
       mbit != `ISC_LAST_BIT);

   isc_brg #(.W(BRG_W)) u_brg (
      .clk_sys(clk_sys),
      .rst(rst),
      .load(brg_load),
      .hold(m_st == isc_pkg::MS_RISE),
      .reload(brg_rl),
      .zero(brg_zero)
   );

   always_ff @(posedge clk_sys) begin
      if (rst || !en) begin
         m_st <= isc_pkg::MS_IDLE;
         mbit <= 4'h0;
         mtx <= 8'h00;
         m_scl_low <= 1'b0;
         m_sda_low <= 1'b0;
         m_ev <= 1'b0;
      end else begin
         m_ev <= 1'b0;
         case (m_st)
            isc_pkg::MS_IDLE: begin
               if (m_go) begin
                  mtx <= wr_data[7:0];
                  mbit <= 4'h0;
                  m_scl_low <= 1'b1;
                  m_sda_low <= !wr_data[7];
                  m_st <= isc_pkg::MS_LOW;
               end
            end
            isc_pkg::MS_LOW: begin
               if (brg_zero) begin
                  m_scl_low <= 1'b0;
                  m_st <= isc_pkg::MS_RISE;
               end
            end
            isc_pkg::MS_RISE: begin
               // a slave stretching us keeps the high phase from starting
               if (scl_s)
                  m_st <= isc_pkg::MS_HIGH;
            end
            isc_pkg::MS_HIGH: begin
               if (m_coll) begin
                  m_sda_low <= 1'b0;
                  m_ev <= 1'b1;
                  m_st <= isc_pkg::MS_IDLE;
               end else if (brg_zero) begin
                  if (mbit == `ISC_LAST_BIT) begin
                     m_ev <= 1'b1;
                     m_st <= isc_pkg::MS_IDLE;
                  end else begin
                     mbit <= mbit + 4'h1;
                     mtx <= {mtx[6:0], 1'b1};
                     m_sda_low <= !mtx[6];
                     m_scl_low <= 1'b1;
                     m_st <= isc_pkg::MS_LOW;
                  end
               end
            end
            default: m_st <= isc_pkg::MS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         slv_scl_low <= 1'b0;
         pin_oe <= 4'h0;
         pin_out <= 4'h0;
         slew_control_disable <= 1'b0;
         smbus_level_enable <= 1'b0;
         master_event_flag <= 1'b0;
         slave_event <= 1'b0;
         rx_done <= 1'b0;
      end else begin
         slv_scl_low <= !ctrl[`ISC_B_REL] && ss != isc_pkg::SL_IDLE;
         if (pin_sel)
            pin_oe <= {2'b00, en && (ack_drv || tx_low || m_sda_low),
                       en && (slv_scl_low || m_scl_low)};
         else
            pin_oe <= {en && (ack_drv || tx_low || m_sda_low),
                       en && (slv_scl_low || m_scl_low), 2'b00};
         pin_out <= 4'h0;
         slew_control_disable <= ctrl[`ISC_B_SLW];
         smbus_level_enable <= ctrl[`ISC_B_SMB];
         master_event_flag <= m_ev || m_coll;
         slave_event <= ev_match;
         rx_done <= ev_rx;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rd_data <= 16'h0000;
      end else if (!rd_en) begin
         rd_data <= 16'h0000;
      end else if (addr == `ISC_A_CTRL) begin
         rd_data <= ctrl;
      end else if (addr == `ISC_A_SADDR) begin
         rd_data <= {6'h00, saddr};
      end else if (addr == `ISC_A_MASK) begin
         rd_data <= {6'h00, amask};
      end else if (addr == `ISC_A_RXBUF) begin
         rd_data <= {8'h00, rxbuf};
      end else if (addr == `ISC_A_TXHOLD) begin
         rd_data <= {8'h00, thr};
      end else if (addr == `ISC_A_BRG) begin
         rd_data <= 16'(brg_rl);
      end else if (addr == `ISC_A_STAT) begin
         rd_data <= {9'h000, rov, bcl, add10, gc_stat, slv_rw, rbf, transmit_buffer_full};
      end else begin
         rd_data <= 16'h0000;
      end
   end

   property p_tx_stretch;
      @(posedge clk_sys) disable iff (rst)
      ack_end && ss == isc_pkg::SL_TX && !transmit_buffer_full && !wr_ctrl
         |=> !ctrl[`ISC_B_REL] ##1 slv_scl_low;
   endproperty
   a_tx_stretch: assert property (p_tx_stretch)
      else $error("transmit stretch not applied");

   property p_hold_pin;
      @(posedge clk_sys) disable iff (rst)
      !ctrl[`ISC_B_REL] && ss != isc_pkg::SL_IDLE && en && pin_sel &&
      !wr_ctrl |-> ##2 pin_oe[0];
   endproperty
   a_hold_pin: assert property (p_hold_pin)
      else $error("clock not held low while stretched");

   property p_rel_ignored;
      @(posedge clk_sys) disable iff (rst)
      wr_ctrl && !stretch_enable && !wr_data[`ISC_B_REL] && ctrl[`ISC_B_REL] &&
      !hw_rel_clr |=> ctrl[`ISC_B_REL];
   endproperty
   a_rel_ignored: assert property (p_rel_ignored)
      else $error("release cleared with stretch disabled");

   property p_collision;
      @(posedge clk_sys) disable iff (rst)
      m_st == isc_pkg::MS_HIGH && !m_sda_low && !sda_s && en
         |=> m_st == isc_pkg::MS_IDLE && master_event_flag && bcl;
   endproperty
   a_collision: assert property (p_collision)
      else $error("collision not handled");

   property p_suspend;
      @(posedge clk_sys) disable iff (rst)
      m_st == isc_pkg::MS_RISE && !scl_s && en
         |=> m_st == isc_pkg::MS_RISE;
   endproperty
   a_suspend: assert property (p_suspend)
      else $error("high phase began while clock low");

   property p_high_time;
      @(posedge clk_sys) disable iff (rst)
      m_st == isc_pkg::MS_RISE && scl_s && en && brg_rl >= BRG_W'(2)
         |=> m_st == isc_pkg::MS_HIGH && !brg_zero;
   endproperty
   a_high_time: assert property (p_high_time)
      else $error("counter not reloaded for high phase");

   property p_accept_all;
      @(posedge clk_sys) disable iff (rst)
      ack_slot && ss == isc_pkg::SL_ADDR && accept_all_addresses_enable && !start_c && !stop_c
         |=> ack_drv && slave_event;
   endproperty
   a_accept_all: assert property (p_accept_all)
      else $error("address refused in accept-all mode");

   property p_gcall;
      @(posedge clk_sys) disable iff (rst)
      ack_slot && ss == isc_pkg::SL_ADDR && !ten_bit_address_select && shreg == 8'h00 &&
      !accept_all_addresses_enable && !start_c && !stop_c
         |=> ack_drv == $past(ctrl[`ISC_B_GENERAL_CALL_ENABLE]);
   endproperty
   a_gcall: assert property (p_gcall)
      else $error("general call answer wrong");

   property p_rx_move;
      @(posedge clk_sys) disable iff (rst)
      ev_rx |=> rbf && rx_done && rxbuf == $past(shreg);
   endproperty
   a_rx_move: assert property (p_rx_move)
      else $error("received byte not moved");

   property p_reset_vals;
      @(posedge clk_sys) disable iff (rst)
      $past(rst) |-> ctrl == `ISC_CTRL_RST;
   endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("control reset value wrong");
endmodule // isc_top

// >>> tb/isc_i2c_master_model.sv
`timescale 1ns/1ns
module isc_i2c_master_model (
   input wire logic scl, // clock wire level
   input wire logic sda, // data wire level
   output logic scl_low, // pull clock wire low
   output logic sda_low // pull data wire low
);
   int n_stuck = 0;
   initial begin
      scl_low = 1'b0;
      sda_low = 1'b0;
   end
   // a competing master holding the data wire
   task automatic pull_sda(input logic v);
      sda_low = v;
   endtask
   // a stretching slave may hold the clock; the wait is bounded
   task automatic rise();
      int k;
      scl_low = 1'b0;
      for (k = 0; k < 2000 && scl !== 1'b1; k++) #10;
      if (scl !== 1'b1) n_stuck++;
      #40;
   endtask
   task automatic start();
      sda_low = 1'b1;
      #40 scl_low = 1'b1;
      #40;
   endtask
   // data moves a little after the clock fall, never beside it
   task automatic stop();
      #10 sda_low = 1'b1;
      #30 rise();
      sda_low = 1'b0;
      #40;
   endtask
   task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                       output logic ack);
      for (int i = 7; i >= 0; i--) begin
         #10 sda_low = ~d[i];
         #30 rise();
         q[i] = sda;
         scl_low = 1'b1;
      end
      #10 sda_low = 1'b0;
      #30 rise();
      ack = ~sda;
      scl_low = 1'b1;
   endtask
endmodule // isc_i2c_master_model

// >>> tb/test_isc_top.sv
`timescale 1ns/1ns
`include "isc_regs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
 $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_isc_top;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic psel = 1'b1;
   logic [2:0] addr = 3'h0;
   logic [15:0] wr_data = 16'h0000;
   logic [15:0] rd_data, v;
   logic [3:0] pin_in, pin_out, pin_oe;
   logic slew, smb, mev, sev, rxd, m_scl, m_sda, k, e, gc;
   logic [7:0] q, d;
   logic [6:0] a, msk;
   int n_mismatch = 0;
   int cmp_count = 0;
   int n_sev = 0;
   int n_rx = 0;
   int n_mev = 0;
   int s0, m;
   wire [1:0] own_oe = psel ? pin_oe[1:0] : pin_oe[3:2];
   wire scl_w = ~(m_scl | own_oe[0]);
   wire sda_w = ~(m_sda | own_oe[1]);
   assign pin_in = psel ? {2'b11, sda_w, scl_w} : {sda_w, scl_w, 2'b11};
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (sev === 1'b1) n_sev++;
      if (rxd === 1'b1) n_rx++;
      if (mev === 1'b1) n_mev++;
   end
   isc_top isc_top_inst (.clk_sys(clk_sys), .rst(rst), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .alternate_pin_select(psel), .slew_control_disable(slew),
      .smbus_level_enable(smb), .master_event_flag(mev),
      .slave_event(sev), .rx_done(rxd));
   isc_i2c_master_model isc_i2c_master_model_inst (.scl(scl_w),
      .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda));
   task automatic do_reset();
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (4) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [2:0] ad, input logic [15:0] dt);
      @(posedge clk_sys);
      addr <= ad;
      wr_data <= dt;
      wr_en <= 1'b1;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] ad);
      @(posedge clk_sys);
      addr <= ad;
      rd_en <= 1'b1;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1 v = rd_data;
   endtask
   task automatic frame(input logic [7:0] b, input logic ex);
      s0 = n_sev;
      isc_i2c_master_model_inst.start();
      isc_i2c_master_model_inst.xfer(b, q, k);
      isc_i2c_master_model_inst.stop();
      `CHK(k, ex)
      `CHK(n_sev - s0, int'(ex))
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #900000 n_mismatch++;
      wrap_up();
   end
   initial begin
      void'($urandom(8928));
      do_reset();
      rd(`ISC_A_CTRL);
      `CHK(v, 16'h1000)
      wr(`ISC_A_SADDR, 16'h002a);
      // modes: plain, masked, accept-all, general call off/on
      for (int i = 0; i < 12; i++) begin
         m = i % 4;
         msk = (m == 1) ? 7'($urandom) : 7'h00;
         a = (m == 3) ? 7'h00 : (i < 4 ? 7'h2a : 7'h08 + 7'($urandom % 112));
         gc = (m == 3) && (i > 3);
         wr(`ISC_A_MASK, {9'h000, msk});
         wr(`ISC_A_CTRL, {4'h8, m == 2, 3'h0, gc, 7'h00});
         e = (m == 2) || (gc && a == 7'h00) || (a >= 7'h08 && a <= 7'h77
             && ((a ^ 7'h2a) & ~msk) == 7'h00);
         frame({a, 1'b0}, e);
      end
      wr(`ISC_A_MASK, 16'h0000);
      wr(`ISC_A_SADDR, 16'h02a5);
      wr(`ISC_A_CTRL, 16'h8400);
      frame(8'hf2, 1'b0);
      isc_i2c_master_model_inst.start();
      isc_i2c_master_model_inst.xfer(8'hf4, q, k);
      `CHK(k, 1'b1)
      isc_i2c_master_model_inst.xfer(8'ha5, q, k);
      `CHK(k, 1'b1)
      isc_i2c_master_model_inst.stop();
      wr(`ISC_A_SADDR, 16'h002a);
      wr(`ISC_A_CTRL, 16'h8000);
      rd(`ISC_A_CTRL);
      `CHK(v, 16'h9000)
      wr(`ISC_A_CTRL, 16'h8340);
      rd(`ISC_A_CTRL);
      `CHK(v, 16'h9340)
      `CHK({slew, smb}, 2'b11)
      // receive with stretching: clock held until release is written
      wr(`ISC_A_CTRL, 16'h9000);
      d = 8'($urandom);
      isc_i2c_master_model_inst.start();
      isc_i2c_master_model_inst.xfer(8'h54, q, k);
      wr(`ISC_A_CTRL, 16'h9040);
      s0 = n_rx;
      isc_i2c_master_model_inst.xfer(d, q, k);
      repeat (20) @(posedge clk_sys);
      `CHK(own_oe[0], 1'b1)
      `CHK(pin_out, 4'h0)
      `CHK(n_rx - s0, 1)
      rd(`ISC_A_RXBUF);
      `CHK(v[7:0], d)
      wr(`ISC_A_CTRL, 16'h9040);
      repeat (6) @(posedge clk_sys);
      `CHK(own_oe[0], 1'b0)
      isc_i2c_master_model_inst.stop();
      // transmit stretches even with stretch enable clear
      wr(`ISC_A_CTRL, 16'h9000);
      d = 8'($urandom);
      isc_i2c_master_model_inst.start();
      isc_i2c_master_model_inst.xfer(8'h55, q, k);
      repeat (20) @(posedge clk_sys);
      `CHK(own_oe[0], 1'b1)
      rd(`ISC_A_CTRL);
      `CHK(v[12], 1'b0)
      wr(`ISC_A_TXHOLD, {8'h00, d});
      wr(`ISC_A_CTRL, 16'h9000);
      isc_i2c_master_model_inst.xfer(8'hff, q, k);
      `CHK(q, d)
      isc_i2c_master_model_inst.stop();
      // own master byte, then one lost to a data line held low
      s0 = n_mev;
      wr(`ISC_A_MTX, {8'h00, d});
      repeat (300) @(posedge clk_sys);
      `CHK(n_mev - s0, 1)
      rd(`ISC_A_STAT);
      `CHK(v[`ISC_S_BCL], 1'b0)
      isc_i2c_master_model_inst.pull_sda(1'b1);
      s0 = n_mev;
      wr(`ISC_A_MTX, 16'h00ff);
      repeat (100) @(posedge clk_sys);
      `CHK(n_mev - s0 > 0, 1'b1)
      rd(`ISC_A_STAT);
      `CHK(v[`ISC_S_BCL], 1'b1)
      isc_i2c_master_model_inst.pull_sda(1'b0);
      @(posedge clk_sys);
      psel <= 1'b0;
      do_reset();
      wr(`ISC_A_SADDR, 16'h002a);
      wr(`ISC_A_CTRL, 16'h8000);
      frame(8'h54, 1'b1);
      `CHK(isc_i2c_master_model_inst.n_stuck, 0)
      wrap_up();
   end
endmodule // test_isc_top
